// [hw/imuds_defines.svh]
`ifndef IMUDS_DEFINES_SVH
`define IMUDS_DEFINES_SVH

// Link command addresses (7-bit, even = low byte, odd = high byte)
`define IMUDS_ADDR_NVM_CNT   7'h00
`define IMUDS_ADDR_AUX_LO    7'h30
`define IMUDS_ADDR_AUX_HI    7'h31
`define IMUDS_ADDR_MISC_LO   7'h34
`define IMUDS_ADDR_MISC_HI   7'h35
`define IMUDS_ADDR_SMPL      7'h36
`define IMUDS_ADDR_FILT_LO   7'h38
`define IMUDS_ADDR_FILT_HI   7'h39
`define IMUDS_ADDR_DIAG      7'h3c
`define IMUDS_ADDR_GLOB      7'h3e

// Field positions
`define IMUDS_GLOB_DAC_LATCH 2
`define IMUDS_MISC_STIM_POS  8
`define IMUDS_MISC_STIM_NEG  9
`define IMUDS_MISC_SELFTEST  10
`define IMUDS_MISC_CKSUM     11
`define IMUDS_DIAG_ZF        15
`define IMUDS_DIAG_YF        14
`define IMUDS_DIAG_XF        13
`define IMUDS_DIAG_GYRO      10
`define IMUDS_DIAG_ALM2      9
`define IMUDS_DIAG_ALM1      8
`define IMUDS_DIAG_CKSUM     6
`define IMUDS_DIAG_STDIAG    5
`define IMUDS_DIAG_OVR       4
`define IMUDS_DIAG_SPI       3
`define IMUDS_DIAG_FLASH     2
`define IMUDS_DIAG_VHI       1
`define IMUDS_DIAG_VLO       0

// Masks and reset values
`define IMUDS_AUX_MASK       16'h0fff
`define IMUDS_AUX_RESET      16'h0000
`define IMUDS_MISC_MASK      16'h0fc7
`define IMUDS_MISC_RESET     16'h0000
`define IMUDS_DIAG_USED      16'he77f
`define IMUDS_DIAG_SUPPLY    16'h0003
`define IMUDS_DIAG_RESET     16'h0000

// Timing
`define IMUDS_WORD_BITS      16
`define IMUDS_CLK_MHZ        100
`define IMUDS_SELFTEST_MS    35
`define IMUDS_SELFTEST_CYC   (`IMUDS_SELFTEST_MS * 1000 * `IMUDS_CLK_MHZ)
`define IMUDS_CKSUM_MS       20
`define IMUDS_CKSUM_CYC      (`IMUDS_CKSUM_MS * 1000 * `IMUDS_CLK_MHZ)
`define IMUDS_CKSUM_RUN_CYC  (`IMUDS_CKSUM_CYC / 2)
`define IMUDS_SETTLE_MS      50
`define IMUDS_SETTLE_CYC     (`IMUDS_SETTLE_MS * 1000 * `IMUDS_CLK_MHZ)
`define IMUDS_SCLK_HALF      4'd4

// Host controller registers (byte addresses)
`define IMUDS_H_TX           8'h00
`define IMUDS_H_CFG          8'h04
`define IMUDS_H_RX           8'h08
`define IMUDS_H_STAT         8'h0c
`define IMUDS_H_ISTAT        8'h10
`define IMUDS_H_IMASK        8'h14
`define IMUDS_H_CFG_RESET    5'd16
`define IMUDS_H_INT_DONE     0
`define IMUDS_H_INT_HOLD     1

`endif

// [hw/imuds_pkg.sv]
package imuds_pkg;
  typedef enum logic [4:0] {
    IMUDS_H_IDLE  = 5'b00001,
    IMUDS_H_LEAD  = 5'b00010,
    IMUDS_H_SHIFT = 5'b00100,
    IMUDS_H_TRAIL = 5'b01000,
    IMUDS_H_HOLD  = 5'b10000
  } imuds_hstate_t;
endpackage : imuds_pkg

// [hw/imuds_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface imuds_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_b, output mosi, input miso);
  modport dev (input sclk, input cs_b, input mosi, output miso);
endinterface : imuds_if
`default_nettype wire

// [hw/imuds_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module imuds_timer (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [31:0] load,
  output logic             busy,
  output logic             done
);
  logic [31:0] cnt_r;
  logic        busy_r;

  // Restart on start; load of zero behaves as one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= 32'h0000_0000;
      busy_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= (load == 32'h0000_0000) ? 32'h0000_0000 : load - 32'h0000_0001;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == 32'h0000_0000) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end

  assign busy = busy_r;
  assign done = busy_r && (cnt_r == 32'h0000_0000) && !start;
endmodule : imuds_timer
`default_nettype wire

// [hw/imuds_device.sv]
// Summary of operation
// - Staged aux bytes move to DAC on latch
// - Aux level is 12-bit offset binary, top unused
// - Host writes low, high, then latch command
// - Self-test bit runs routine, records fail flags
// - Self-test finishes in 35 ms, sets flags
// - Self-test start bit clears itself when done
// - Bits 9 and 8 drive stimulus while set
// - Host waits 50 ms after stimulus changes; host holds 20 ms if that write also sets bit 11
// - Flash writes increment the write counter
// - Bit 11 runs checksum; read after 20 ms
// - Diagnostic read clears flags except supply
// - Persisting conditions re-set flags next sample
// - Supply flags follow supply, ignore reads
// - Bits 15..13, 10, 5 report self-test fails
// - Bits 9, 8 show alarm 2, 1 active
// - Bit 3 set on non-16-multiple clock count
// - Bits 4, 6, 2: overrange, checksum, flash fail
// - Bit 1 supply high, bit 0 supply low
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "imuds_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module imuds_device #(
  parameter logic [31:0] SELFTEST_CYC = `IMUDS_SELFTEST_CYC,
  parameter logic [31:0] CKSUM_CYC    = `IMUDS_CKSUM_RUN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  imuds_if.dev             link,
  input  wire logic        sample_tick,
  input  wire logic [4:0]  st_fail_in,
  input  wire logic        alarm1_in,
  input  wire logic        alarm2_in,
  input  wire logic        overrange_in,
  input  wire logic        supply_hi_in,
  input  wire logic        supply_lo_in,
  input  wire logic        flash_write_in,
  input  wire logic        flash_fail_in,
  input  wire logic        cksum_mismatch_in,
  output logic [11:0]      dac_level,
  output logic             stim_pos,
  output logic             stim_neg,
  output logic             selftest_busy,
  output logic             cksum_busy
);
  // Command word decode: write flag and address match
  function automatic logic wr_to(input logic [15:0] w, input logic [6:0] a);
    wr_to = w[15] && (w[14:8] == a);
  endfunction : wr_to

  logic        sclk_q_r;
  logic        cs_q_r;
  logic [15:0] rx_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] tx_r;
  logic [15:0] rd_word_r;
  logic [15:0] aux_r;
  logic [11:0] dac_r;
  logic [15:0] misc_r;
  logic [15:0] misc_nxt;
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] nvm_cnt_r;
  logic [4:0]  st_res_r;
  logic        ck_res_r;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        word_done;
  logic [15:0] word;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [6:0]  rd_addr;
  logic        spi_err_ev;
  logic        st_start;
  logic        st_done;
  logic        ck_start;
  logic        ck_done;
  logic [15:0] cond;
  logic [15:0] set_v;
  logic [15:0] clr_v;

  // Link edge detection; pins are synchronous to clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q_r <= 1'b1;
      cs_q_r   <= 1'b1;
    end else begin
      sclk_q_r <= link.sclk;
      cs_q_r   <= link.cs_b;
    end
  end

  assign sclk_rise = link.sclk && !sclk_q_r && !link.cs_b;
  assign sclk_fall = !link.sclk && sclk_q_r && !link.cs_b;
  assign cs_fall   = !link.cs_b && cs_q_r;
  assign cs_rise   = link.cs_b && !cs_q_r;
  assign word_done = sclk_rise && (bit_cnt_r == 4'hf);
  assign word      = {rx_r[14:0], link.mosi};
  assign cmd_wr    = word_done && word[15];
  assign cmd_rd    = word_done && !word[15];
  assign rd_addr   = {word[14:9], 1'b0};
  assign spi_err_ev = cs_rise && (bit_cnt_r != 4'h0);

  // Receive shifter and bit counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r      <= 16'h0000;
      bit_cnt_r <= 4'h0;
    end else if (cs_fall) begin
      bit_cnt_r <= 4'h0;
    end else if (sclk_rise) begin
      rx_r      <= word;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Transmit shifter: each word returns the previous read answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_r <= 16'h0000;
    end else if (cs_fall) begin
      tx_r <= rd_word_r;
    end else if (sclk_fall) begin
      if (bit_cnt_r == 4'h0) begin
        tx_r <= rd_word_r;
      end else begin
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  assign link.miso = tx_r[15];

  // Read answer capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_word_r <= 16'h0000;
    end else if (cmd_rd) begin
      case (rd_addr)
        `IMUDS_ADDR_NVM_CNT: begin
          rd_word_r <= nvm_cnt_r;
        end
        `IMUDS_ADDR_AUX_LO: begin
          rd_word_r <= aux_r & `IMUDS_AUX_MASK;
        end
        `IMUDS_ADDR_MISC_LO: begin
          rd_word_r <= misc_r;
        end
        `IMUDS_ADDR_DIAG: begin
          rd_word_r <= flags_r & `IMUDS_DIAG_USED;
        end
        default: begin
          rd_word_r <= 16'h0000;
        end
      endcase
    end
  end

  // Staging register for the aux level, 12 data bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_r <= `IMUDS_AUX_RESET;
    end else if (word_done && wr_to(word, `IMUDS_ADDR_AUX_LO)) begin
      aux_r[7:0] <= word[7:0];
    end else if (word_done && wr_to(word, `IMUDS_ADDR_AUX_HI)) begin
      aux_r[15:8] <= {4'h0, word[3:0]};
    end
  end

  // DAC input register takes both bytes at once on latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_r <= 12'h000;
    end else if (cmd_wr && wr_to(word, `IMUDS_ADDR_GLOB) && word[`IMUDS_GLOB_DAC_LATCH]) begin
      dac_r <= aux_r[11:0];
    end
  end

  assign dac_level = dac_r;

  // Start pulses for the two timed routines
  assign st_start = cmd_wr && wr_to(word, `IMUDS_ADDR_MISC_HI) && word[`IMUDS_MISC_SELFTEST - 8];
  assign ck_start = cmd_wr && wr_to(word, `IMUDS_ADDR_MISC_HI) && word[`IMUDS_MISC_CKSUM - 8];

  imuds_timer u_st_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (st_start),
    .load  (SELFTEST_CYC),
    .busy  (selftest_busy),
    .done  (st_done)
  );

  imuds_timer u_ck_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (ck_start),
    .load  (CKSUM_CYC),
    .busy  (cksum_busy),
    .done  (ck_done)
  );

  // Control register with self-clearing start bits; a new write wins
  always_comb begin
    misc_nxt = misc_r;
    if (st_done) begin
      misc_nxt[`IMUDS_MISC_SELFTEST] = 1'b0;
    end
    if (ck_done) begin
      misc_nxt[`IMUDS_MISC_CKSUM] = 1'b0;
    end
    if (word_done && wr_to(word, `IMUDS_ADDR_MISC_LO)) begin
      misc_nxt[7:0] = word[7:0] & 8'(`IMUDS_MISC_MASK);
    end
    if (word_done && wr_to(word, `IMUDS_ADDR_MISC_HI)) begin
      misc_nxt[15:8] = word[7:0] & 8'(`IMUDS_MISC_MASK >> 8);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_r <= `IMUDS_MISC_RESET;
    end else begin
      misc_r <= misc_nxt;
    end
  end

  assign stim_pos = misc_r[`IMUDS_MISC_STIM_POS];
  assign stim_neg = misc_r[`IMUDS_MISC_STIM_NEG];

  // Routine results, held as persisting conditions
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_res_r <= 5'h00;
    end else if (st_done) begin
      st_res_r <= st_fail_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_res_r <= 1'b0;
    end else if (ck_done) begin
      ck_res_r <= cksum_mismatch_in;
    end
  end

  // Flash write counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_cnt_r <= 16'h0000;
    end else if (flash_write_in) begin
      nvm_cnt_r <= nvm_cnt_r + 16'h0001;
    end
  end

  // Diagnostic flags: set wins over the read clear
  always_comb begin
    cond = 16'h0000;
    cond[`IMUDS_DIAG_ZF]     = st_res_r[4];
    cond[`IMUDS_DIAG_YF]     = st_res_r[3];
    cond[`IMUDS_DIAG_XF]     = st_res_r[2];
    cond[`IMUDS_DIAG_GYRO]   = st_res_r[1];
    cond[`IMUDS_DIAG_STDIAG] = st_res_r[0];
    cond[`IMUDS_DIAG_ALM2]   = alarm2_in;
    cond[`IMUDS_DIAG_ALM1]   = alarm1_in;
    cond[`IMUDS_DIAG_CKSUM]  = ck_res_r;
    cond[`IMUDS_DIAG_OVR]    = overrange_in;
    set_v = sample_tick ? cond : 16'h0000;
    if (st_done) begin
      set_v[`IMUDS_DIAG_ZF]     = set_v[`IMUDS_DIAG_ZF] | st_fail_in[4];
      set_v[`IMUDS_DIAG_YF]     = set_v[`IMUDS_DIAG_YF] | st_fail_in[3];
      set_v[`IMUDS_DIAG_XF]     = set_v[`IMUDS_DIAG_XF] | st_fail_in[2];
      set_v[`IMUDS_DIAG_GYRO]   = set_v[`IMUDS_DIAG_GYRO] | st_fail_in[1];
      set_v[`IMUDS_DIAG_STDIAG] = set_v[`IMUDS_DIAG_STDIAG] | st_fail_in[0];
    end
    if (ck_done) begin
      set_v[`IMUDS_DIAG_CKSUM] = set_v[`IMUDS_DIAG_CKSUM] | cksum_mismatch_in;
    end
    set_v[`IMUDS_DIAG_SPI]   = set_v[`IMUDS_DIAG_SPI] | spi_err_ev;
    set_v[`IMUDS_DIAG_FLASH] = set_v[`IMUDS_DIAG_FLASH] | flash_fail_in;
    clr_v = (cmd_rd && (rd_addr == `IMUDS_ADDR_DIAG)) ? ~`IMUDS_DIAG_SUPPLY : 16'h0000;
    flags_nxt = ((flags_r & ~clr_v) | set_v) & `IMUDS_DIAG_USED;
    flags_nxt[`IMUDS_DIAG_VHI] = supply_hi_in;
    flags_nxt[`IMUDS_DIAG_VLO] = supply_lo_in;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= `IMUDS_DIAG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule : imuds_device
`default_nettype wire

// [hw/imuds_host.sv]
`include "imuds_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module imuds_host #(
  parameter logic [31:0] SETTLE_CYC = `IMUDS_SETTLE_CYC,
  parameter logic [31:0] CKSUM_CYC  = `IMUDS_CKSUM_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  imuds_if.host            link
);
  imuds_pkg::imuds_hstate_t st_r;
  logic [7:0]  a_addr_r;
  logic        a_wr_r;
  logic        a_rd_r;
  logic [31:0] hrdata_r;
  logic [4:0]  cfg_bits_r;
  logic [15:0] tx_r;
  logic [15:0] sent_r;
  logic [15:0] rx_r;
  logic [4:0]  cnt_r;
  logic [3:0]  div_r;
  logic        sclk_r;
  logic        cs_b_r;
  logic [1:0]  istat_r;
  logic [1:0]  imask_r;
  logic        take;
  logic        tx_wr;
  logic        half;
  logic        frame_end;
  logic        hold_start;
  logic [31:0] hold_load;
  logic        hold_busy;
  logic        hold_done;
  logic [1:0]  ev;

  assign take      = hsel && hready && htrans[1];
  assign tx_wr     = a_wr_r && (a_addr_r == `IMUDS_H_TX) && (st_r == imuds_pkg::IMUDS_H_IDLE);
  assign half      = (div_r == `IMUDS_SCLK_HALF - 4'd1);
  assign frame_end = (st_r == imuds_pkg::IMUDS_H_TRAIL) && half;
  assign hreadyout = !a_rd_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Bus address phase capture; reads take one wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_addr_r <= 8'h00;
      a_wr_r   <= 1'b0;
      a_rd_r   <= 1'b0;
    end else begin
      a_wr_r <= take && hwrite;
      a_rd_r <= take && !hwrite;
      if (take) begin
        a_addr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_r <= 32'h0000_0000;
    end else if (a_rd_r) begin
      case (a_addr_r)
        `IMUDS_H_TX: hrdata_r <= {16'h0000, sent_r};
        `IMUDS_H_CFG: hrdata_r <= {27'h0000000, cfg_bits_r};
        `IMUDS_H_RX: hrdata_r <= {16'h0000, rx_r};
        `IMUDS_H_STAT: hrdata_r <= {30'h00000000, hold_busy, st_r != imuds_pkg::IMUDS_H_IDLE};
        `IMUDS_H_ISTAT: hrdata_r <= {30'h00000000, istat_r};
        `IMUDS_H_IMASK: hrdata_r <= {30'h00000000, imask_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_bits_r <= `IMUDS_H_CFG_RESET;
    end else if (a_wr_r && (a_addr_r == `IMUDS_H_CFG)) begin
      cfg_bits_r <= hwdata[4:0];
    end
  end

  // Interrupt status: write one to clear, a new event wins
  assign ev[`IMUDS_H_INT_DONE] = frame_end;
  assign ev[`IMUDS_H_INT_HOLD] = hold_done;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      istat_r <= 2'b00;
      imask_r <= 2'b00;
    end else begin
      if (a_wr_r && (a_addr_r == `IMUDS_H_ISTAT)) begin
        istat_r <= (istat_r & ~hwdata[1:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      if (a_wr_r && (a_addr_r == `IMUDS_H_IMASK)) begin
        imask_r <= hwdata[1:0];
      end
    end
  end

  assign irq = |(istat_r & imask_r);

  // Frame engine: one command word per frame, idle-high clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r   <= imuds_pkg::IMUDS_H_IDLE;
      tx_r   <= 16'h0000;
      sent_r <= 16'h0000;
      rx_r   <= 16'h0000;
      cnt_r  <= 5'd0;
      div_r  <= 4'd0;
      sclk_r <= 1'b1;
      cs_b_r <= 1'b1;
    end else begin
      div_r <= half ? 4'd0 : div_r + 4'd1;
      case (st_r)
        imuds_pkg::IMUDS_H_IDLE: begin
          div_r <= 4'd0;
          if (tx_wr) begin
            tx_r   <= hwdata[15:0];
            sent_r <= hwdata[15:0];
            cnt_r  <= 5'd0;
            cs_b_r <= 1'b0;
            st_r   <= imuds_pkg::IMUDS_H_LEAD;
          end
        end
        imuds_pkg::IMUDS_H_LEAD: begin
          if (half) begin
            if (cfg_bits_r == 5'd0) begin
              st_r <= imuds_pkg::IMUDS_H_TRAIL;
            end else begin
              sclk_r <= 1'b0;
              st_r   <= imuds_pkg::IMUDS_H_SHIFT;
            end
          end
        end
        imuds_pkg::IMUDS_H_SHIFT: begin
          if (half) begin
            if (!sclk_r) begin
              sclk_r <= 1'b1;
              rx_r   <= {rx_r[14:0], link.miso};
              cnt_r  <= cnt_r + 5'd1;
            end else if (cnt_r == cfg_bits_r) begin
              st_r <= imuds_pkg::IMUDS_H_TRAIL;
            end else begin
              sclk_r <= 1'b0;
              tx_r   <= {tx_r[14:0], 1'b0};
            end
          end
        end
        imuds_pkg::IMUDS_H_TRAIL: begin
          if (half) begin
            cs_b_r <= 1'b1;
            st_r   <= hold_start ? imuds_pkg::IMUDS_H_HOLD : imuds_pkg::IMUDS_H_IDLE;
          end
        end
        imuds_pkg::IMUDS_H_HOLD: begin
          if (hold_done) begin
            st_r <= imuds_pkg::IMUDS_H_IDLE;
          end
        end
        default: begin
          st_r <= imuds_pkg::IMUDS_H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_b = cs_b_r;
  assign link.mosi = tx_r[15];

  // Hold-off after stimulus, configuration or checksum commands
  always_comb begin
    hold_start = 1'b0;
    hold_load  = SETTLE_CYC;
    if (frame_end && sent_r[15]) begin
      if (sent_r[14:8] == `IMUDS_ADDR_MISC_HI) begin
        hold_start = 1'b1;
        if (sent_r[`IMUDS_MISC_CKSUM - 8]) begin
          hold_load = CKSUM_CYC;
        end
      end
      if ((sent_r[14:8] == `IMUDS_ADDR_SMPL) || (sent_r[14:8] == `IMUDS_ADDR_FILT_LO) ||
          (sent_r[14:8] == `IMUDS_ADDR_FILT_HI)) begin
        hold_start = 1'b1;
      end
    end
  end

  imuds_timer u_hold_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (hold_start),
    .load  (hold_load),
    .busy  (hold_busy),
    .done  (hold_done)
  );
endmodule : imuds_host
`default_nettype wire

// [verification/imuds_props.sv]
`timescale 1ns/100ps
`default_nettype none
module imuds_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic miso
);
  logic       sclk_q_r;
  logic [5:0] rise_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q_r <= 1'b1;
    end else begin
      sclk_q_r <= sclk;
    end
  end
  // Rising edges counted within one frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_r <= 6'h00;
    end else if (cs_b) begin
      rise_r <= 6'h00;
    end else if (sclk && !sclk_q_r) begin
      rise_r <= rise_r + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence lead_s; sclk [*4] ##1 !sclk; endsequence
  sequence low_s; !sclk [*4] ##1 sclk; endsequence
  idle_clock_a: assert property (cs_b |-> sclk) else $error("sclk low outside a frame");
  lead_time_a: assert property ($fell(cs_b) |-> lead_s) else $error("lead time wrong");
  low_half_a: assert property ($fell(sclk) |-> low_s) else $error("sclk low phase wrong");
  high_half_a: assert property ($rose(sclk) |-> sclk [*4]) else $error("sclk high phase wrong");
  mosi_hold_a: assert property (!cs_b && !$past(cs_b) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  trail_time_a: assert property ($rose(cs_b) |-> $past(sclk, 4) && $past(sclk))
    else $error("trail time wrong");
  frame_bits_a: assert property ($rose(cs_b) |-> rise_r <= 6'd31) else $error("too many clocks");
  reset_idle_a: assert property ($rose(rst_b) |-> cs_b && sclk && !mosi) else $error("link not idle");
endmodule : imuds_props
`default_nettype wire

// [verification/imu_diagnostics_status_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module imu_diagnostics_status_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, irq;
  logic        tick = 1'b0, alm1 = 1'b0, alm2 = 1'b0, ovr = 1'b0, vhi = 1'b0, vlo = 1'b0;
  logic        fwr = 1'b0, ffail = 1'b0, ckm = 1'b0;
  logic [4:0]  stf = 5'h00;
  logic [11:0] dac;
  logic        spos, sneg, stb, ckb;
  logic [15:0] v;
  int          err_total = 0;
  int          checks = 0;
  always #5 clk = ~clk;
  imuds_if link_if ();
  imuds_host #(.SETTLE_CYC(32'd300), .CKSUM_CYC(32'd200)) imuds_host_inst (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link_if.host));
  imuds_device #(.SELFTEST_CYC(32'd200), .CKSUM_CYC(32'd100)) imuds_device_inst (.clk(clk), .rst_b(rst_b),
    .link(link_if.dev), .sample_tick(tick), .st_fail_in(stf), .alarm1_in(alm1), .alarm2_in(alm2),
    .overrange_in(ovr), .supply_hi_in(vhi), .supply_lo_in(vlo), .flash_write_in(fwr), .flash_fail_in(ffail),
    .cksum_mismatch_in(ckm), .dac_level(dac), .stim_pos(spos), .stim_neg(sneg), .selftest_busy(stb),
    .cksum_busy(ckb));
  imuds_props imuds_props_inst (.clk(clk), .rst_b(rst_b), .sclk(link_if.sclk), .cs_b(link_if.cs_b),
    .mosi(link_if.mosi), .miso(link_if.miso));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ready is judged mid-cycle, then the edge at which it was high is passed
  task automatic wait_rdy(output logic [31:0] q);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        err_total++;
        final_report();
      end
      @(negedge clk);
    end
    q = hrdata;
    @(posedge clk);
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy(q);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic idle;
    logic [31:0] q;
    for (int n = 0; n < 2000; n++) begin
      rd(8'h0c, q);
      if (q[1:0] === 2'b00) return;
    end
    err_total++;
    final_report();
  endtask : idle
  task automatic cmd(input logic [15:0] w);
    wr(8'h00, {16'h0000, w});
    idle();
  endtask : cmd
  // Answer of a read comes back during the following word
  task automatic dread(input logic [6:0] a, output logic [15:0] r);
    logic [31:0] q;
    cmd({1'b0, a, 8'h00});
    cmd(16'h0000);
    rd(8'h08, q);
    r = q[15:0];
  endtask : dread
  task automatic pulse;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic t_dac;
    cmd(16'hb0d9);
    chk(dac, 12'h000);
    cmd(16'hb1f4);
    chk(dac, 12'h000);
    cmd(16'hbe04);
    chk(dac, 12'h4d9);
    dread(7'h30, v);
    chk(v, 16'h04d9);
    $display("t_dac done");
  endtask : t_dac
  task automatic t_stim;
    logic [15:0] w [3] = '{16'hb502, 16'hb501, 16'hb500};
    logic [1:0]  e [3] = '{2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 3; i++) begin
      cmd(w[i]);
      chk({sneg, spos}, e[i]);
    end
    $display("t_stim done");
  endtask : t_stim
  task automatic t_flags;
    alm1 <= 1'b1;
    alm2 <= 1'b1;
    ovr <= 1'b1;
    vhi <= 1'b1;
    ffail <= 1'b1;
    pulse();
    {alm1, alm2, ovr, ffail} <= 4'h0;
    dread(7'h3c, v);
    chk(v, 16'h0316);
    dread(7'h3c, v);
    chk(v, 16'h0002);
    vhi <= 1'b0;
    vlo <= 1'b1;
    dread(7'h3c, v);
    chk(v, 16'h0001);
    vlo <= 1'b0;
    dread(7'h3c, v);
    chk(v, 16'h0000);
    fwr <= 1'b1;
    repeat (3) @(posedge clk);
    fwr <= 1'b0;
    dread(7'h00, v);
    chk(v, 16'h0003);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_misc;
    logic [31:0] q;
    rd(8'h18, q);
    chk(q, 32'h0);
    wr(8'h04, 32'h8);
    cmd(16'h0000);
    wr(8'h04, 32'h10);
    dread(7'h3c, v);
    chk(v, 16'h0008);
    ckm <= 1'b1;
    cmd(16'hb508);
    ckm <= 1'b0;
    dread(7'h3c, v);
    chk(v, 16'h0040);
    chk(ckb, 1'b0);
    chk(hresp, 1'b0);
    chk(irq, 1'b0);
    wr(8'h14, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    wr(8'h10, 32'h3);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    $display("t_misc done");
  endtask : t_misc
  task automatic t_self;
    int n;
    stf <= 5'h15;
    wr(8'h00, 32'hb504);
    for (n = 0; n < 400 && stb !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 400 && stb === 1'b1; n++) @(negedge clk);
    chk(n > 0 && n <= 200, 1'b1);
    @(posedge clk);
    idle();
    dread(7'h34, v);
    chk(v, 16'h0000);
    dread(7'h3c, v);
    chk(v, 16'ha020);
    dread(7'h3c, v);
    chk(v, 16'h0000);
    pulse();
    dread(7'h3c, v);
    chk(v, 16'ha060);
    $display("t_self done");
  endtask : t_self
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(dac, 12'h000);
    dread(7'h3c, v);
    chk(v, 16'h0000);
    t_dac();
    t_stim();
    t_flags();
    t_misc();
    t_self();
    final_report();
  end
endmodule : imu_diagnostics_status_tb
`default_nettype wire
